// ### rtl/ewpwt_pkg.sv
// Package with register map, field layout and mode encodings of the timer channel
package ewpwt_pkg;
  localparam int unsigned EWPWT_AW = 12;
  localparam logic [11:0] EWPWT_MODE_OFF = 12'h000;
  localparam logic [11:0] EWPWT_CTRL_OFF = 12'h004;
  localparam logic [11:0] EWPWT_CMPA_OFF = 12'h008;
  localparam logic [11:0] EWPWT_CMPB_OFF = 12'h00c;
  localparam logic [11:0] EWPWT_STAT_OFF = 12'h010;
  // Mode register fields
  localparam int unsigned EWPWT_MODE_LSB = 0;
  localparam int unsigned EWPWT_CK_LSB = 3;
  localparam int unsigned EWPWT_EDGE_BIT = 5;
  localparam int unsigned EWPWT_CAPT_BIT = 6;
  // Control register fields
  localparam int unsigned EWPWT_RUN_BIT = 0;
  localparam int unsigned EWPWT_OVE_BIT = 1;
  localparam int unsigned EWPWT_ACAP_BIT = 2;
  // Status register fields
  localparam int unsigned EWPWT_CPFA_BIT = 0;
  localparam int unsigned EWPWT_CPFB_BIT = 1;
  localparam int unsigned EWPWT_OVF_BIT = 2;
  // Operating mode encodings
  localparam logic [2:0] EWPWT_M_EVENT = 3'h2;
  localparam logic [2:0] EWPWT_M_WINDOW = 3'h5;
  localparam logic [2:0] EWPWT_M_PWM = 3'h6;
  // Source clock prescale exponents for select 0..3
  localparam logic [3:0] EWPWT_DIV_SEL0 = 4'ha;
  localparam logic [3:0] EWPWT_DIV_SEL1 = 4'h6;
  localparam logic [3:0] EWPWT_DIV_SEL2 = 4'h2;
  localparam logic [3:0] EWPWT_DIV_SEL3 = 4'h1;
  localparam logic [15:0] EWPWT_ZERO16 = 16'h0000;
  localparam logic [15:0] EWPWT_ONE16 = 16'h0001;
  localparam logic [15:0] EWPWT_MAX16 = 16'hffff;
  localparam logic [31:0] EWPWT_ZERO32 = 32'h0000_0000;
  // Measurement sequencer states
  typedef enum logic [1:0] {EWPWT_WAIT_START, EWPWT_HIGH_PHASE, EWPWT_LOW_PHASE} ewpwt_state_e;
endpackage

// ### rtl/ewpwt_timer.sv
// Event, window and pulse width timer channel with an APB register slave
// Operation
// - Event mode counts once run bit set
// - Event mode counts each selected pin edge
// - Compare A match: irq, clear, continue
// - Clearing run bit stops and zeroes counter
// - Window mode counts internal source clock
// - Edge select picks high or low window
// - Window counts at level; match irq clear
// - Mode and overflow enable locked while running
// - Measure mode; edge select picks start edge
// - Capture type: zero double, one single
// - Overflow enable gates overflow interrupt
// - Starting measurement clears both capture registers
// - Start edge irq; opposite captures B
// - Double: next start captures A, clears
// - Single: opposite edge stops, zeroes counter
// - Overflow sets flag regardless of enable
// - Status read clears capture and overflow flags
// - Opposite edge first: no capture, no irq
// - Auto capture: B read snapshots counter outside measure mode
`timescale 1ns/100ps
module ewpwt_timer
  import ewpwt_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned PRE_W = 10
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_timer_input_pin,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [EWPWT_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_timer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic acc;
  logic wr;
  logic rd;
  logic hit_mode;
  logic hit_ctrl;
  logic hit_cmpa;
  logic hit_cmpb;
  logic hit_stat;
  logic hit_any;
  assign acc = i_psel & i_penable & ~o_pready;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  assign hit_mode = (i_paddr == EWPWT_MODE_OFF);
  assign hit_ctrl = (i_paddr == EWPWT_CTRL_OFF);
  assign hit_cmpa = (i_paddr == EWPWT_CMPA_OFF);
  assign hit_cmpb = (i_paddr == EWPWT_CMPB_OFF);
  assign hit_stat = (i_paddr == EWPWT_STAT_OFF);
  assign hit_any = hit_mode | hit_ctrl | hit_cmpa | hit_cmpb | hit_stat;

  logic [2:0] mode_q;
  logic [1:0] ck_q;
  logic edge_sel_q;
  logic capt_single_q;
  logic run_q;
  logic ove_q;
  logic acap_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cmpa_q;
  logic [CNT_W-1:0] cmpb_q;
  logic cpfa_q;
  logic cpfb_q;
  logic ovf_q;
  logic start_pulse;
  logic stop_pulse;
  assign start_pulse = wr & hit_ctrl & ~run_q & i_pwdata[EWPWT_RUN_BIT];
  assign stop_pulse = wr & hit_ctrl & run_q & ~i_pwdata[EWPWT_RUN_BIT];

  // Mode register and overflow enable, frozen while running
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mode_q <= 3'h0;
      ck_q <= 2'h0;
      edge_sel_q <= 1'b0;
      capt_single_q <= 1'b0;
      ove_q <= 1'b0;
    end else if (!run_q) begin
      if (wr && hit_mode) begin
        mode_q <= i_pwdata[EWPWT_MODE_LSB +: 3];
        ck_q <= i_pwdata[EWPWT_CK_LSB +: 2];
        edge_sel_q <= i_pwdata[EWPWT_EDGE_BIT];
        capt_single_q <= i_pwdata[EWPWT_CAPT_BIT];
      end
      if (wr && hit_ctrl) begin
        ove_q <= i_pwdata[EWPWT_OVE_BIT];
      end
    end
  end

  // Run and auto capture bits; auto capture kept at the stop write
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      run_q <= 1'b0;
      acap_q <= 1'b0;
    end else if (wr && hit_ctrl) begin
      run_q <= i_pwdata[EWPWT_RUN_BIT];
      if (!stop_pulse) begin
        acap_q <= i_pwdata[EWPWT_ACAP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detection
  logic pin_m_q;
  logic pin_s_q;
  logic pin_p_q;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pin_m_q <= 1'b0;
      pin_s_q <= 1'b0;
      pin_p_q <= 1'b0;
    end else begin
      pin_m_q <= i_timer_input_pin;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end
  logic rise;
  logic fall;
  logic start_edge;
  logic opp_edge;
  assign rise = pin_s_q & ~pin_p_q;
  assign fall = ~pin_s_q & pin_p_q;
  assign start_edge = edge_sel_q ? fall : rise;
  assign opp_edge = edge_sel_q ? rise : fall;

  ////////////////////////////////////////////////////////////////////////////
  // Source clock prescaler, one tick per divided period
  logic [PRE_W-1:0] pre_q;
  logic [3:0] div_exp;
  logic src_tick;
  always_comb begin
    div_exp = EWPWT_DIV_SEL0;
    if (ck_q == 2'h1) begin
      div_exp = EWPWT_DIV_SEL1;
    end else if (ck_q == 2'h2) begin
      div_exp = EWPWT_DIV_SEL2;
    end else if (ck_q == 2'h3) begin
      div_exp = EWPWT_DIV_SEL3;
    end
  end
  assign src_tick = (pre_q & PRE_W'((1 << div_exp) - 1)) == '0;
  always_ff @(posedge i_clock) begin
    if (i_srst || !run_q) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and measurement sequencer
  ewpwt_state_e st_q;
  logic is_evt;
  logic is_win;
  logic is_pwm;
  logic win_lvl;
  logic cmp_match;
  logic pwm_cnt;
  logic ovf_evt;
  assign is_evt = run_q & (mode_q == EWPWT_M_EVENT);
  assign is_win = run_q & (mode_q == EWPWT_M_WINDOW);
  assign is_pwm = run_q & (mode_q == EWPWT_M_PWM);
  assign win_lvl = edge_sel_q ? ~pin_s_q : pin_s_q;
  assign cmp_match = (cnt_q == cmpa_q);
  assign pwm_cnt = is_pwm & (st_q != EWPWT_WAIT_START) & src_tick;
  assign ovf_evt = pwm_cnt & (cnt_q == CNT_W'(EWPWT_MAX16));

  // Stop write zeroes at once, so no count survives the stopping edge
  always_ff @(posedge i_clock) begin
    if (i_srst || !run_q || stop_pulse) begin
      cnt_q <= '0;
      st_q <= EWPWT_WAIT_START;
    end else if (is_evt || is_win) begin
      if (cmp_match) begin
        cnt_q <= '0;
      end else if (is_evt ? start_edge : (win_lvl & src_tick)) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end else if (is_pwm) begin
      case (st_q)
        EWPWT_WAIT_START: begin
          if (start_edge) begin
            st_q <= EWPWT_HIGH_PHASE;
            cnt_q <= '0;
          end
        end
        EWPWT_HIGH_PHASE: begin
          if (opp_edge) begin
            if (capt_single_q) begin
              st_q <= EWPWT_WAIT_START;
              cnt_q <= '0;
            end else begin
              st_q <= EWPWT_LOW_PHASE;
            end
          end else if (pwm_cnt) begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        EWPWT_LOW_PHASE: begin
          if (start_edge) begin
            st_q <= EWPWT_HIGH_PHASE;
            cnt_q <= '0;
          end else if (pwm_cnt) begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default: begin
          st_q <= EWPWT_WAIT_START;
        end
      endcase
    end
  end

  logic cap_b;
  logic cap_a;
  logic start_irq;
  assign cap_b = is_pwm & (st_q == EWPWT_HIGH_PHASE) & opp_edge;
  assign cap_a = is_pwm & (st_q == EWPWT_LOW_PHASE) & start_edge;
  assign start_irq = is_pwm & (st_q == EWPWT_WAIT_START) & start_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and capture registers; B read snapshots under auto capture outside measure mode
  logic rd_b;
  assign rd_b = rd & hit_cmpb & acap_q & (mode_q != EWPWT_M_PWM);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cmpa_q <= '0;
      cmpb_q <= '0;
    end else begin
      if (start_pulse && mode_q == EWPWT_M_PWM) begin
        cmpa_q <= '0;
        cmpb_q <= '0;
      end else begin
        if (cap_a) begin
          cmpa_q <= cnt_q;
        end else if (wr && hit_cmpa && !is_pwm) begin
          cmpa_q <= i_pwdata[CNT_W-1:0];
        end
        if (cap_b) begin
          cmpb_q <= cnt_q;
        end else if (rd_b) begin
          cmpb_q <= cnt_q;
        end else if (wr && hit_cmpb && !is_pwm) begin
          cmpb_q <= i_pwdata[CNT_W-1:0];
        end
      end
    end
  end

  // Status flags; a new event wins over the clearing read
  logic rd_stat;
  assign rd_stat = rd & hit_stat;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cpfa_q <= 1'b0;
      cpfb_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      cpfa_q <= cap_a | (cpfa_q & ~rd_stat);
      cpfb_q <= cap_b | (cpfb_q & ~rd_stat);
      ovf_q <= ovf_evt | (ovf_q & ~rd_stat);
    end
  end

  // Interrupt request pulse, one cycle per event
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_timer_irq <= 1'b0;
    end else begin
      o_timer_irq <= ((is_evt | is_win) & cmp_match) | start_irq | cap_a | cap_b
                     | (ovf_evt & ove_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, unmapped address gives slave error
  logic [31:0] rdat;
  always_comb begin
    rdat = EWPWT_ZERO32;
    if (hit_mode) begin
      rdat[EWPWT_MODE_LSB +: 3] = mode_q;
      rdat[EWPWT_CK_LSB +: 2] = ck_q;
      rdat[EWPWT_EDGE_BIT] = edge_sel_q;
      rdat[EWPWT_CAPT_BIT] = capt_single_q;
    end else if (hit_ctrl) begin
      rdat[EWPWT_RUN_BIT] = run_q;
      rdat[EWPWT_OVE_BIT] = ove_q;
      rdat[EWPWT_ACAP_BIT] = acap_q;
    end else if (hit_cmpa) begin
      rdat[CNT_W-1:0] = cmpa_q;
    end else if (hit_cmpb) begin
      rdat[CNT_W-1:0] = rd_b ? cnt_q : cmpb_q;
    end else if (hit_stat) begin
      rdat[EWPWT_CPFA_BIT] = cpfa_q;
      rdat[EWPWT_CPFB_BIT] = cpfb_q;
      rdat[EWPWT_OVF_BIT] = ovf_q;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= EWPWT_ZERO32;
    end else begin
      o_pready <= acc;
      o_pslverr <= acc & ~hit_any;
      if (rd) begin
        o_prdata <= rdat;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_stop_zero;
    @(posedge i_clock) disable iff (i_srst) stop_pulse |=> (cnt_q == '0) && !run_q;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("counter not zeroed on stop");
  property p_lock;
    @(posedge i_clock) disable iff (i_srst) run_q && $past(run_q) |-> $stable(mode_q);
  endproperty
  a_lock: assert property (p_lock) else $error("mode changed while running");
  property p_evt_inc;
    @(posedge i_clock) disable iff (i_srst)
      is_evt && start_edge && !cmp_match && !wr |=> cnt_q == $past(cnt_q) + CNT_W'(1);
  endproperty
  a_evt_inc: assert property (p_evt_inc) else $error("event count missed");
  property p_match;
    @(posedge i_clock) disable iff (i_srst)
      (is_evt || is_win) && cmp_match && !wr |=> cnt_q == '0 && o_timer_irq;
  endproperty
  a_match: assert property (p_match) else $error("compare match not handled");
  property p_win_hold;
    @(posedge i_clock) disable iff (i_srst)
      is_win && !win_lvl && !cmp_match && !wr |=> $stable(cnt_q);
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("window counted off level");
  property p_init;
    @(posedge i_clock) disable iff (i_srst)
      start_pulse && mode_q == EWPWT_M_PWM |=> cmpa_q == '0 && cmpb_q == '0;
  endproperty
  a_init: assert property (p_init) else $error("captures not cleared at start");
  sequence s_capb;
    cap_b ##1 (cpfb_q && o_timer_irq);
  endsequence
  property p_capb;
    @(posedge i_clock) disable iff (i_srst) cap_b |-> s_capb;
  endproperty
  a_capb: assert property (p_capb) else $error("capture B not flagged");
  property p_capa;
    @(posedge i_clock) disable iff (i_srst) cap_a |=> cpfa_q && cnt_q == '0;
  endproperty
  a_capa: assert property (p_capa) else $error("capture A wrong");
  property p_single;
    @(posedge i_clock) disable iff (i_srst)
      cap_b && capt_single_q && !wr |=> st_q == EWPWT_WAIT_START && cnt_q == '0;
  endproperty
  a_single: assert property (p_single) else $error("single capture not stopped");
  property p_first_opp;
    @(posedge i_clock) disable iff (i_srst)
      is_pwm && st_q == EWPWT_WAIT_START && opp_edge && !wr |=> !o_timer_irq;
  endproperty
  a_first_opp: assert property (p_first_opp) else $error("irq on first opposite edge");
  property p_ovf;
    @(posedge i_clock) disable iff (i_srst) ovf_evt |=> ovf_q && (o_timer_irq == $past(ove_q));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow handling wrong");
  property p_clr;
    @(posedge i_clock) disable iff (i_srst)
      rd_stat && !cap_a && !cap_b && !ovf_evt |=> !cpfa_q && !cpfb_q && !ovf_q;
  endproperty
  a_clr: assert property (p_clr) else $error("status read did not clear");

endmodule

// ### verification/ewpwt_pulse_src.sv
// Model of the external pulse source that drives the timer input pin
`timescale 1ns/100ps
module ewpwt_pulse_src (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_go,
  input wire logic i_idle,
  input wire logic [7:0] i_first_cyc,
  input wire logic [7:0] i_second_cyc,
  input wire logic [7:0] i_num,
  output logic o_pin,
  output logic o_busy
);
  logic [7:0] tmr_q;
  logic [7:0] left_q;
  logic phase_q;
  logic [7:0] first_w;
  logic [7:0] second_w;
  ////////////////////////////////////////
  // Levels never shorter than two cycles, so no edge is lost
  assign first_w = (i_first_cyc < 8'd2) ? 8'd2 : i_first_cyc;
  assign second_w = (i_second_cyc < 8'd2) ? 8'd2 : i_second_cyc;
  ////////////////////////////////////////
  // Pulse train: active level first, then idle level
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pin <= i_idle;
      o_busy <= 1'b0;
      phase_q <= 1'b0;
    end else if (!o_busy) begin
      o_pin <= i_go ? ~i_idle : i_idle;
      o_busy <= i_go;
      phase_q <= 1'b0;
      tmr_q <= first_w;
      left_q <= i_num;
    end else if (tmr_q > 8'd1) begin
      tmr_q <= tmr_q - 8'd1;
    end else if (!phase_q) begin
      o_pin <= i_idle;
      phase_q <= 1'b1;
      tmr_q <= second_w;
    end else if (left_q > 8'd1) begin
      o_pin <= ~i_idle;
      phase_q <= 1'b0;
      tmr_q <= first_w;
      left_q <= left_q - 8'd1;
    end else begin
      o_busy <= 1'b0;
    end
  end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the event, window and pulse width timer
`timescale 1ns/100ps
`define CHK(g, e) check((g), (e))
module tb_top;
  import ewpwt_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic src_go, src_idle, src_busy;
  logic [7:0] src_a, src_b, src_n;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc_n = 0;
  int irq_n = 0;

  // Narrow counter so that an overflow fits inside the run
  ewpwt_timer #(.CNT_W(6)) i_dut (.i_clock(clk), .i_srst(srst), .i_timer_input_pin(pin),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_timer_irq(irq));
  ewpwt_pulse_src i_src (.i_clock(clk), .i_srst(srst), .i_go(src_go),
    .i_idle(src_idle), .i_first_cyc(src_a), .i_second_cyc(src_b), .i_num(src_n),
    .o_pin(pin), .o_busy(src_busy));

  always #10 clk = ~clk;
  ////////////////////////////////////////
  // Interrupt pulse tally and hang guard
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (cyc_n == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 40) error_cnt++;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    `CHK(r, exp);
  endtask
  // Pulse train from the source; settle time covers synchroniser delay
  task automatic pulses(input logic idle, input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] n);
    int k;
    k = 0;
    src_idle <= idle;
    src_a <= a;
    src_b <= b;
    src_n <= n;
    src_go <= 1'b1;
    @(posedge clk);
    src_go <= 1'b0;
    do begin
      @(posedge clk);
      k++;
    end while (src_busy === 1'b1 && k < 3000);
    repeat (5) @(posedge clk);
  endtask
  // Measurement run: opposite edge first, then start, opposite, start
  task automatic measure(input logic es, input logic single);
    logic [31:0] v;
    int i0;
    src_idle <= ~es;
    wr(EWPWT_MODE_OFF, {25'h0, single, es, 2'b11, EWPWT_M_PWM});
    wr(EWPWT_CMPA_OFF, 32'h1234);
    wr(EWPWT_CMPB_OFF, 32'h5678);
    wr(EWPWT_CTRL_OFF, 32'h1);
    rd_chk(EWPWT_CMPA_OFF, 32'h0);
    rd_chk(EWPWT_CMPB_OFF, 32'h0);
    i0 = irq_n;
    pulses(~es, 8'd20, 8'd30, 8'd2);
    `CHK(irq_n - i0, 3);
    // Captures are read before any further edge arrives
    rd(EWPWT_CMPB_OFF, v);
    `CHK(v >= 13 && v <= 17, 1);
    rd(EWPWT_CMPA_OFF, v);
    `CHK(single ? v == 0 : v >= 23 && v <= 27, 1);
    rd_chk(EWPWT_STAT_OFF, single ? 32'h2 : 32'h3);
    rd_chk(EWPWT_STAT_OFF, 32'h0);
    wr(EWPWT_CTRL_OFF, 32'h0);
  endtask
  // Long high pulse wraps the narrowed counter exactly once
  task automatic ovf_run(input logic ove);
    int i0;
    wr(EWPWT_MODE_OFF, 32'h1e);
    wr(EWPWT_CTRL_OFF, {30'h0, ove, 1'b1});
    i0 = irq_n;
    pulses(1'b0, 8'd200, 8'd4, 8'd1);
    `CHK(irq_n - i0, ove ? 3 : 2);
    rd_chk(EWPWT_STAT_OFF, 32'h6);
    wr(EWPWT_CTRL_OFF, 32'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic e;
    int i0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_go = 1'b0;
    src_idle = 1'b0;
    src_a = 8'h02;
    src_b = 8'h02;
    src_n = 8'h01;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Reset state and an unmapped slot
    for (int a = 0; a < 5; a++) rd_chk(12'(a * 4), 32'h0);
    xfer(1'b0, 12'h014, 32'h0, v, e);
    `CHK(v, 32'h0);
    `CHK({31'h0, e}, 32'h1);
    // Event counting with compare clear
    wr(EWPWT_MODE_OFF, {29'h0, EWPWT_M_EVENT});
    wr(EWPWT_CMPA_OFF, 32'h5);
    pulses(1'b0, 8'd3, 8'd3, 8'd2);
    wr(EWPWT_CTRL_OFF, 32'h5);
    rd_chk(EWPWT_CMPB_OFF, 32'h0);
    pulses(1'b0, 8'd3, 8'd3, 8'd3);
    rd_chk(EWPWT_CMPB_OFF, 32'h3);
    i0 = irq_n;
    pulses(1'b0, 8'd3, 8'd3, 8'd2);
    rd_chk(EWPWT_CMPB_OFF, 32'h0);
    `CHK(irq_n - i0, 1);
    pulses(1'b0, 8'd3, 8'd3, 8'd1);
    rd_chk(EWPWT_CMPB_OFF, 32'h1);
    wr(EWPWT_MODE_OFF, {29'h0, EWPWT_M_WINDOW});
    wr(EWPWT_CTRL_OFF, 32'h7);
    rd_chk(EWPWT_MODE_OFF, {29'h0, EWPWT_M_EVENT});
    rd_chk(EWPWT_CTRL_OFF, 32'h5);
    wr(EWPWT_CTRL_OFF, 32'h4);
    rd_chk(EWPWT_CMPB_OFF, 32'h0);
    // Window counting, tick every second clock
    wr(EWPWT_MODE_OFF, 32'h1d);
    wr(EWPWT_CMPA_OFF, 32'hffff);
    wr(EWPWT_CTRL_OFF, 32'h5);
    repeat (40) @(posedge clk);
    rd_chk(EWPWT_CMPB_OFF, 32'h0);
    pulses(1'b0, 8'd40, 8'd4, 8'd1);
    rd(EWPWT_CMPB_OFF, v);
    `CHK(v >= 18 && v <= 22, 1);
    wr(EWPWT_CTRL_OFF, 32'h4);
    wr(EWPWT_MODE_OFF, 32'h3d);
    wr(EWPWT_CMPA_OFF, 32'h3);
    i0 = irq_n;
    wr(EWPWT_CTRL_OFF, 32'h5);
    repeat (40) @(posedge clk);
    `CHK(irq_n - i0 >= 3, 1);
    rd(EWPWT_CMPB_OFF, v);
    `CHK(v <= 3, 1);
    wr(EWPWT_CTRL_OFF, 32'h0);
    // Pulse width: both start edges, double and single capture
    for (int m = 0; m < 4; m++) measure(m[0], m[1]);
    // Overflow with and without its interrupt enabled
    ovf_run(1'b1);
    ovf_run(1'b0);
    finish_test();
  end
endmodule
